// ### verilog/serial_link_tx_dev.sv
`timescale 1ns/10ps
// Overview of operation
// - Enabled timestamp rides on every sample LSB
// - Timestamp latency equals its sample latency
// - Software also enables timestamp input receiver
// - Timestamp at N-field bit zero, ADC LSB kept
// - Lane alignment always reports zero control bits
// - Link enable bit, resets to enabled
// - Disabled: reset, serializers down, clocks gated
// - Disabled: multiframe counter held, SYSREF ignored
// - Clear link enable before other changes
// - Calibration on before link, off after
// - Six-bit mode field selects output mode
// - Mode changes only with both enables clear
// - Frames per multiframe minus one, reset 0x1F
// - Software keeps K legal for mode
// - 64B/66B modes use K = 256*E/F
// - K changes only while link disabled
// - Reserved bits always written as zero
module serial_link_tx_dev (
  input  wire logic          CLK_SYS_I,        // 25 MHz system clock
  input  wire logic          SRST_I,           // Synchronous reset, high
  serial_link_cfg_if.dev     cfg,              // Register port
  input  wire logic [11:0]   ADC_SAMPLE_I,     // Converter sample
  input  wire logic          ADC_TIMESTAMP_I,  // Timestamp, same cycle as sample
  input  wire logic          ADC_VALID_I,      // Sample valid
  output logic               ADC_READY_O,      // Sample accepted
  input  wire logic          SYSREF_I,         // SYSREF pin, asynchronous
  output logic [15:0]        LINK_DATA_O,      // N-bit link sample
  output logic               LINK_VALID_O,     // Link sample valid
  input  wire logic          LINK_READY_I,     // Link accepts sample
  output logic               LINK_RST_O,       // Link subsystem reset
  output logic               SERDES_PD_O,      // Serializer power down
  output logic               CLK_GATE_EN_O,    // Subsystem clock enable
  output logic [5:0]         MODE_O,           // Active output mode
  output logic [7:0]         K_EFF_M1_O,       // Effective K minus one
  output logic [7:0]         MF_COUNT_O,       // Multiframe clock counter
  output logic               ILA_CS_O          // Control bits advertised in ILA
);
  localparam int N  = serial_link_tx_pkg::LINK_N;
  localparam int AW = serial_link_tx_pkg::ADC_W;

  logic       timestamp_insert_enable;
  logic       link_subsystem_enable;
  logic [5:0] link_output_mode_select;
  logic [7:0] frames_per_multiframe_minus_one;
  logic       cfg_hit;
  logic [7:0] next_rdata;
  logic       sysref_meta;
  logic       sysref_sync;
  logic       sysref_prev;
  logic       fifo_rst;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic [N-1:0] fifo_out_data;
  logic [N-1:0] next_word;
  logic       out_load;
  logic [7:0] next_k_m1;
  logic       is_64b66b;
  logic [8:0] k_full;

  //////////////////////////////////////////////////////////////////////////////
  // Register port
  assign cfg_hit = cfg.req_valid && !cfg.ack;

  always_comb begin
    next_rdata = 8'h00;
    unique case (cfg.req_addr)
      serial_link_tx_pkg::TIMESTAMP_LSB_CONTROL_OFS:
        next_rdata[serial_link_tx_pkg::TS_INSERT_BIT] = timestamp_insert_enable;
      serial_link_tx_pkg::LINK_ENABLE_OFS:
        next_rdata[serial_link_tx_pkg::LINK_EN_BIT] = link_subsystem_enable;
      serial_link_tx_pkg::LINK_OUTPUT_MODE_OFS:
        next_rdata[5:0] = link_output_mode_select;
      serial_link_tx_pkg::FRAMES_PER_MULTIFRAME_M1_OFS:
        next_rdata = frames_per_multiframe_minus_one;
      default:
        next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      cfg.ack   <= 1'b0;
      cfg.rdata <= 8'h00;
    end else begin
      cfg.ack <= cfg_hit;
      if (cfg_hit && !cfg.req_write) begin
        cfg.rdata <= next_rdata;
      end
    end
  end

  // Reserved bits are not stored, so they always read back zero
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      timestamp_insert_enable <=
        serial_link_tx_pkg::TIMESTAMP_LSB_CONTROL_RST[serial_link_tx_pkg::TS_INSERT_BIT];
      link_subsystem_enable <=
        serial_link_tx_pkg::LINK_ENABLE_RST[serial_link_tx_pkg::LINK_EN_BIT];
      link_output_mode_select <= serial_link_tx_pkg::LINK_OUTPUT_MODE_RST[5:0];
      frames_per_multiframe_minus_one <=
        serial_link_tx_pkg::FRAMES_PER_MULTIFRAME_M1_RST;
    end else if (cfg_hit && cfg.req_write) begin
      unique case (cfg.req_addr)
        serial_link_tx_pkg::TIMESTAMP_LSB_CONTROL_OFS:
          timestamp_insert_enable <= cfg.req_wdata[serial_link_tx_pkg::TS_INSERT_BIT];
        serial_link_tx_pkg::LINK_ENABLE_OFS:
          link_subsystem_enable <= cfg.req_wdata[serial_link_tx_pkg::LINK_EN_BIT];
        serial_link_tx_pkg::LINK_OUTPUT_MODE_OFS:
          link_output_mode_select <= cfg.req_wdata[5:0];
        serial_link_tx_pkg::FRAMES_PER_MULTIFRAME_M1_OFS:
          frames_per_multiframe_minus_one <= cfg.req_wdata;
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Link control outputs
  // 64B/66B modes: E is 1 and F is 2^mode[1:0], so K = 256 >> mode[1:0]
  assign is_64b66b = (link_output_mode_select >= serial_link_tx_pkg::MODE_64B66B_FIRST);
  assign k_full    = 9'(serial_link_tx_pkg::K_64B66B_SCALE) >> link_output_mode_select[1:0];
  assign next_k_m1 = is_64b66b ? 8'(k_full - 9'h001)
                               : frames_per_multiframe_minus_one;

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      LINK_RST_O    <= 1'b1;
      SERDES_PD_O   <= 1'b1;
      CLK_GATE_EN_O <= 1'b0;
      MODE_O        <= 6'h00;
      K_EFF_M1_O    <= 8'h00;
      ILA_CS_O      <= 1'b0;
    end else begin
      LINK_RST_O    <= !link_subsystem_enable;
      SERDES_PD_O   <= !link_subsystem_enable;
      CLK_GATE_EN_O <= link_subsystem_enable;
      MODE_O        <= link_output_mode_select;
      K_EFF_M1_O    <= next_k_m1;
      ILA_CS_O      <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Multiframe clock counter
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      sysref_meta <= 1'b0;
      sysref_sync <= 1'b0;
      sysref_prev <= 1'b0;
    end else begin
      sysref_meta <= SYSREF_I;
      sysref_sync <= sysref_meta;
      sysref_prev <= sysref_sync;
    end
  end

  // Counts frames, one per link sample handed out
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I || !link_subsystem_enable) begin
      MF_COUNT_O <= 8'h00;
    end else if (sysref_sync && !sysref_prev) begin
      MF_COUNT_O <= 8'h00;
    end else if (LINK_VALID_O && LINK_READY_I) begin
      MF_COUNT_O <= (MF_COUNT_O >= K_EFF_M1_O) ? 8'h00 : MF_COUNT_O + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sample path
  // Timestamp travels in the same word as its sample, so both see one latency
  always_comb begin
    next_word = '0;
    next_word[N-1 -: AW] = ADC_SAMPLE_I;
    next_word[0] = timestamp_insert_enable && ADC_TIMESTAMP_I;
  end

  assign fifo_rst    = SRST_I || !link_subsystem_enable;
  assign ADC_READY_O = fifo_in_ready && link_subsystem_enable;
  assign out_load    = fifo_out_valid && (!LINK_VALID_O || LINK_READY_I);

  sample_fifo #(
    .WIDTH (N),
    .DEPTH (serial_link_tx_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (CLK_SYS_I),
    .srst_i      (fifo_rst),
    .in_valid_i  (ADC_VALID_I && link_subsystem_enable),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (next_word),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (!LINK_VALID_O || LINK_READY_I),
    .out_data_o  (fifo_out_data)
  );

  always_ff @(posedge CLK_SYS_I) begin
    if (fifo_rst) begin
      LINK_VALID_O <= 1'b0;
      LINK_DATA_O  <= '0;
    end else begin
      if (out_load) begin
        LINK_DATA_O <= fifo_out_data;
      end
      if (out_load) begin
        LINK_VALID_O <= 1'b1;
      end else if (LINK_READY_I) begin
        LINK_VALID_O <= 1'b0;
      end
    end
  end
endmodule

// ### verilog/serial_link_tx_pkg.sv
package serial_link_tx_pkg;
  // Device register offsets on the configuration port
  localparam logic [9:0] TIMESTAMP_LSB_CONTROL_OFS    = 10'h160;
  localparam logic [9:0] LINK_ENABLE_OFS              = 10'h200;
  localparam logic [9:0] LINK_OUTPUT_MODE_OFS         = 10'h201;
  localparam logic [9:0] FRAMES_PER_MULTIFRAME_M1_OFS = 10'h202;
  // Reset values
  localparam logic [7:0] TIMESTAMP_LSB_CONTROL_RST    = 8'h00;
  localparam logic [7:0] LINK_ENABLE_RST              = 8'h01;
  localparam logic [7:0] LINK_OUTPUT_MODE_RST         = 8'h00;
  localparam logic [7:0] FRAMES_PER_MULTIFRAME_M1_RST = 8'h1F;
  // Field layouts
  localparam int         TS_INSERT_BIT   = 0;
  localparam int         LINK_EN_BIT     = 0;
  localparam int         MODE_W          = 6;
  localparam logic [7:0] TS_FIELD_MASK   = 8'h01;
  localparam logic [7:0] EN_FIELD_MASK   = 8'h01;
  localparam logic [7:0] MODE_FIELD_MASK = 8'h3F;
  localparam logic [7:0] KM1_FIELD_MASK  = 8'hFF;
  // Mode encoding: codes at or above this value use the 64B/66B link layer
  localparam logic [5:0] MODE_64B66B_FIRST = 6'h20;
  localparam int         K_64B66B_SCALE    = 256;
  // Sample path
  localparam int         ADC_W       = 12;
  localparam int         LINK_N      = 16;
  localparam int         FIFO_DEPTH  = 8;
  localparam int         CFG_ADDR_W  = 10;
  localparam int         CFG_DATA_W  = 8;
  // Controller APB map
  localparam logic [7:0] CTL_CMD_OFS    = 8'h00;
  localparam logic [7:0] CTL_STATUS_OFS = 8'h04;
  localparam logic [7:0] CTL_CAL_OFS    = 8'h08;
  localparam int         CMD_WDATA_LSB  = 0;
  localparam int         CMD_ADDR_LSB   = 8;
  localparam int         CMD_WRITE_BIT  = 24;
  localparam int         ST_BUSY_BIT    = 0;
  localparam int         ST_REFUSED_BIT = 1;
  localparam int         ST_RDATA_LSB   = 8;
endpackage

// ### verilog/serial_link_cfg_if.sv
`timescale 1ns/10ps
interface serial_link_cfg_if;
  logic       req_valid;
  logic       req_write;
  logic [9:0] req_addr;
  logic [7:0] req_wdata;
  logic       ack;
  logic [7:0] rdata;
  modport dev (input req_valid, req_write, req_addr, req_wdata, output ack, rdata);
  modport ctl (output req_valid, req_write, req_addr, req_wdata, input ack, rdata);
endinterface

// ### verilog/sample_fifo.sv
`timescale 1ns/10ps
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,    // System clock
  input  wire logic             srst_i,   // Synchronous reset, high
  input  wire logic             in_valid_i, // Write request
  output logic                  in_ready_o, // Not full
  input  wire logic [WIDTH-1:0] in_data_i,  // Write word
  output logic                  out_valid_o, // Not empty
  input  wire logic             out_ready_i, // Read accept
  output logic      [WIDTH-1:0] out_data_o   // Head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem[rd_ptr];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ### verilog/serial_link_tx_ctl.sv
`timescale 1ns/10ps
module serial_link_tx_ctl (
  input  wire logic        CLK_SYS_I,      // 25 MHz system clock
  input  wire logic        SRST_I,         // Synchronous reset, high
  serial_link_cfg_if.ctl   cfg,            // Device register port
  input  wire logic        PSEL_I,         // APB select
  input  wire logic        PENABLE_I,      // APB access phase
  input  wire logic        PWRITE_I,       // APB direction
  input  wire logic [7:0]  PADDR_I,        // APB byte address
  input  wire logic [31:0] PWDATA_I,       // APB write data
  output logic             PREADY_O,       // APB ready
  output logic [31:0]      PRDATA_O,       // APB read data
  output logic             PSLVERR_O,      // APB error, always low
  output logic             CAL_EN_O,       // Calibration enable
  output logic             TS_RECV_EN_O    // Timestamp input receiver enable
);
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_WAIT = 1'b1} ctl_state_e;

  ctl_state_e state;
  logic       link_on;
  logic       refused;
  logic [7:0] rdata;
  logic       apb_acc;
  logic       cmd_wr;
  logic       cal_wr;
  logic       cmd_write;
  logic [9:0] cmd_addr;
  logic [7:0] cmd_data;
  logic [7:0] clean_data;
  logic       allow;

  assign apb_acc   = PSEL_I && PENABLE_I && !PREADY_O;
  assign cmd_wr    = apb_acc && PWRITE_I && (PADDR_I == serial_link_tx_pkg::CTL_CMD_OFS);
  assign cal_wr    = apb_acc && PWRITE_I && (PADDR_I == serial_link_tx_pkg::CTL_CAL_OFS);
  assign cmd_write = PWDATA_I[serial_link_tx_pkg::CMD_WRITE_BIT];
  assign cmd_addr  = PWDATA_I[serial_link_tx_pkg::CMD_ADDR_LSB +: 10];
  assign cmd_data  = PWDATA_I[serial_link_tx_pkg::CMD_WDATA_LSB +: 8];

  // Interlocks on writes to the device
  always_comb begin
    clean_data = 8'h00;
    allow      = 1'b1;
    unique case (cmd_addr)
      serial_link_tx_pkg::TIMESTAMP_LSB_CONTROL_OFS: begin
        clean_data = cmd_data & serial_link_tx_pkg::TS_FIELD_MASK;
        allow      = !link_on;
      end
      serial_link_tx_pkg::LINK_ENABLE_OFS: begin
        clean_data = cmd_data & serial_link_tx_pkg::EN_FIELD_MASK;
        allow      = !clean_data[0] || CAL_EN_O;
      end
      serial_link_tx_pkg::LINK_OUTPUT_MODE_OFS: begin
        clean_data = cmd_data & serial_link_tx_pkg::MODE_FIELD_MASK;
        allow      = !link_on && !CAL_EN_O;
      end
      serial_link_tx_pkg::FRAMES_PER_MULTIFRAME_M1_OFS: begin
        clean_data = cmd_data & serial_link_tx_pkg::KM1_FIELD_MASK;
        allow      = !link_on;
      end
      default: begin
        clean_data = 8'h00;
        allow      = !link_on;
      end
    endcase
    if (!cmd_write) begin
      allow = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Device request
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      state         <= ST_IDLE;
      cfg.req_valid <= 1'b0;
      cfg.req_write <= 1'b0;
      cfg.req_addr  <= '0;
      cfg.req_wdata <= 8'h00;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (cmd_wr && allow) begin
            state         <= ST_WAIT;
            cfg.req_valid <= 1'b1;
            cfg.req_write <= cmd_write;
            cfg.req_addr  <= cmd_addr;
            cfg.req_wdata <= clean_data;
          end
        end
        ST_WAIT: begin
          if (cfg.ack) begin
            state         <= ST_IDLE;
            cfg.req_valid <= 1'b0;
          end
        end
      endcase
    end
  end

  // Shadow of the device link enable, which comes up enabled
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      link_on      <= serial_link_tx_pkg::LINK_ENABLE_RST[0];
      TS_RECV_EN_O <= 1'b0;
    end else if (state == ST_WAIT && cfg.ack && cfg.req_write) begin
      if (cfg.req_addr == serial_link_tx_pkg::LINK_ENABLE_OFS) begin
        link_on <= cfg.req_wdata[0];
      end
      if (cfg.req_addr == serial_link_tx_pkg::TIMESTAMP_LSB_CONTROL_OFS) begin
        TS_RECV_EN_O <= cfg.req_wdata[0];
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      rdata <= 8'h00;
    end else if (state == ST_WAIT && cfg.ack && !cfg.req_write) begin
      rdata <= cfg.rdata;
    end
  end

  // Calibration may only drop once the link is off
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      CAL_EN_O <= 1'b0;
      refused  <= 1'b0;
    end else begin
      if (cal_wr && (PWDATA_I[0] || !link_on)) begin
        CAL_EN_O <= PWDATA_I[0];
      end
      if ((cmd_wr && (!allow || state != ST_IDLE)) || (cal_wr && !PWDATA_I[0] && link_on)) begin
        refused <= 1'b1;
      end else if (cmd_wr) begin
        refused <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB slave, one wait state
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      PREADY_O  <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O  <= apb_acc;
      PSLVERR_O <= 1'b0;
      if (apb_acc && !PWRITE_I) begin
        PRDATA_O <= 32'h0000_0000;
        if (PADDR_I == serial_link_tx_pkg::CTL_STATUS_OFS) begin
          PRDATA_O[serial_link_tx_pkg::ST_BUSY_BIT]       <= (state != ST_IDLE);
          PRDATA_O[serial_link_tx_pkg::ST_REFUSED_BIT]    <= refused;
          PRDATA_O[serial_link_tx_pkg::ST_RDATA_LSB +: 8] <= rdata;
        end else if (PADDR_I == serial_link_tx_pkg::CTL_CAL_OFS) begin
          PRDATA_O[0] <= CAL_EN_O;
        end
      end
    end
  end
endmodule

// ### dv/serial_link_tx_monitor.sv
`timescale 1ns/10ps
module serial_link_tx_monitor (
  input wire logic        CLK_SYS_I,     // System clock
  input wire logic        SRST_I,        // Sync reset
  input wire logic        req_valid,     // Config request
  input wire logic        req_write,     // Config direction
  input wire logic [9:0]  req_addr,      // Config offset
  input wire logic [7:0]  req_wdata,     // Config write byte
  input wire logic        ack,           // Config answer
  input wire logic [7:0]  rdata,         // Config read byte
  input wire logic [15:0] LINK_DATA_O,   // Link word
  input wire logic        LINK_VALID_O,  // Link valid
  input wire logic        LINK_READY_I,  // Link ready
  input wire logic        LINK_RST_O,    // Link reset
  input wire logic        SERDES_PD_O,   // Serializer down
  input wire logic        CLK_GATE_EN_O, // Clock enable
  input wire logic [7:0]  K_EFF_M1_O,    // K minus one
  input wire logic [7:0]  MF_COUNT_O,    // Multiframe count
  input wire logic        ILA_CS_O       // Lane alignment control bits
);
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (SRST_I);
  ////////////////////////////////////////
  chk_ack_next: assert property (req_valid && !ack |=> ack)
    else $error("config ack missing");
  chk_ack_pulse: assert property (ack |=> !ack)
    else $error("config ack too long");
  chk_ack_cause: assert property (ack |-> $past(req_valid))
    else $error("config ack without request");
  chk_req_hold: assert property (req_valid && !ack |=> req_valid && $stable(req_addr)
      && $stable(req_wdata) && $stable(req_write))
    else $error("config request changed early");
  chk_req_drop: assert property (ack |=> !req_valid)
    else $error("config request not released");
  // Read data may only move with an answered read, else software sees stale bytes
  chk_rdata_cause: assert property ($changed(rdata) |-> ack && !req_write)
    else $error("read data moved without read");
  chk_ila_zero: assert property (ILA_CS_O == 1'b0)
    else $error("alignment reports control bits");
  chk_off_state: assert property (SERDES_PD_O == LINK_RST_O
      && CLK_GATE_EN_O == !LINK_RST_O)
    else $error("power and clock disagree with reset");
  chk_mf_held: assert property (LINK_RST_O |-> MF_COUNT_O == 8'h00 && !LINK_VALID_O)
    else $error("link active while disabled");
  chk_mf_range: assert property (MF_COUNT_O <= K_EFF_M1_O)
    else $error("multiframe count beyond K");
  chk_pad_zero: assert property (LINK_VALID_O |-> LINK_DATA_O[3:1] == 3'h0)
    else $error("pad bits not zero");
  chk_out_hold: assert property (LINK_VALID_O && !LINK_READY_I
      |=> !LINK_VALID_O || $stable(LINK_DATA_O))
    else $error("link word changed while stalled");
endmodule

// ### dv/serial_link_tx_config_regs_bench.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin \
  checks_done++; \
  if ((got) !== (ex)) begin \
    n_fail++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, (ex), (got)); \
  end \
end
module serial_link_tx_config_regs_bench;
  logic        CLK_SYS_I = 1'b0, SRST_I = 1'b1, SYSREF_I = 1'b0, LINK_READY_I = 1'b0;
  logic        ADC_VALID_I = 1'b0, ADC_TIMESTAMP_I = 1'b0, PSEL_I = 1'b0, PENABLE_I = 1'b0;
  logic        PWRITE_I = 1'b0;
  logic [11:0] ADC_SAMPLE_I = 12'h000;
  logic [7:0]  PADDR_I = 8'h00;
  logic [31:0] PWDATA_I = 32'h0000_0000;
  logic        ADC_READY_O, LINK_VALID_O, LINK_RST_O, SERDES_PD_O, CLK_GATE_EN_O, ILA_CS_O;
  logic        PREADY_O, PSLVERR_O, CAL_EN_O, TS_RECV_EN_O;
  logic [15:0] LINK_DATA_O, sink_w;
  logic [5:0]  MODE_O;
  logic [7:0]  K_EFF_M1_O, MF_COUNT_O;
  logic [31:0] PRDATA_O, q;
  logic [11:0] smp;
  logic        ts;
  // Model state
  int          n_fail = 0, checks_done = 0, m_ts, m_en, m_mode, m_km1, m_cal, m_refl, mf;
  bit          sink_on = 1'b0;
  logic [15:0] exp_q[$];
  logic [9:0]  addrs[5] = '{10'h160, 10'h200, 10'h201, 10'h202, 10'h0A5};

  serial_link_cfg_if cfg_bus ();
  serial_link_tx_dev i_serial_link_tx_dev (.CLK_SYS_I, .SRST_I, .cfg(cfg_bus), .ADC_SAMPLE_I,
    .ADC_TIMESTAMP_I, .ADC_VALID_I, .ADC_READY_O, .SYSREF_I, .LINK_DATA_O, .LINK_VALID_O,
    .LINK_READY_I, .LINK_RST_O, .SERDES_PD_O, .CLK_GATE_EN_O, .MODE_O, .K_EFF_M1_O,
    .MF_COUNT_O, .ILA_CS_O);
  serial_link_tx_ctl i_serial_link_tx_ctl (.CLK_SYS_I, .SRST_I, .cfg(cfg_bus), .PSEL_I,
    .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PREADY_O, .PRDATA_O, .PSLVERR_O, .CAL_EN_O,
    .TS_RECV_EN_O);
  serial_link_tx_monitor i_serial_link_tx_monitor (.CLK_SYS_I, .SRST_I,
    .req_valid(cfg_bus.req_valid), .req_write(cfg_bus.req_write), .req_addr(cfg_bus.req_addr),
    .req_wdata(cfg_bus.req_wdata), .ack(cfg_bus.ack), .rdata(cfg_bus.rdata), .LINK_DATA_O,
    .LINK_VALID_O, .LINK_READY_I, .LINK_RST_O, .SERDES_PD_O, .CLK_GATE_EN_O, .K_EFF_M1_O,
    .MF_COUNT_O, .ILA_CS_O);

  always #20 CLK_SYS_I = ~CLK_SYS_I;
  ////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tmo();
    n_fail++;
    $display("CHECK FAILED wait_bound exp 0 got 1");
    print_verdict();
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int g;
    @(posedge CLK_SYS_I);
    PSEL_I <= 1'b1;
    PENABLE_I <= 1'b0;
    PWRITE_I <= wr;
    PADDR_I <= a;
    PWDATA_I <= d;
    @(posedge CLK_SYS_I);
    PENABLE_I <= 1'b1;
    g = 0;
    do begin
      @(posedge CLK_SYS_I);
      g++;
    end while (PREADY_O !== 1'b1 && g < 20);
    if (PREADY_O !== 1'b1) tmo();
    r = PRDATA_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
  endtask
  // Polls busy, so a slow device answer never hides behind a fixed delay
  task automatic dcmd(input logic wr, input logic [9:0] a, input logic [7:0] d,
                      output logic [31:0] st);
    int g;
    apb(1'b1, 8'h00, {7'h00, wr, 6'h00, a, d}, q);
    g = 0;
    st = 32'h0000_0001;
    while (st[0] !== 1'b0 && g < 20) begin
      apb(1'b0, 8'h04, 32'h0000_0000, st);
      g++;
    end
    if (st[0] !== 1'b0) tmo();
  endtask
  function automatic logic [7:0] rd_exp(input logic [9:0] a);
    case (a)
      10'h160: return 8'(m_ts);
      10'h200: return 8'(m_en);
      10'h201: return 8'(m_mode);
      10'h202: return 8'(m_km1);
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] keff();
    return (m_mode >= 32) ? 8'((256 >> (m_mode % 4)) - 1) : 8'(m_km1);
  endfunction
  function automatic logic refuse(input logic [9:0] a, input logic [7:0] d);
    case (a)
      10'h201: return m_en == 1 || m_cal == 1;
      10'h200: return d[0] && m_cal == 0;
      default: return m_en == 1;
    endcase
  endfunction
  task automatic out_chk();
    `CHK("mode", MODE_O, m_mode[5:0])
    `CHK("k_eff", K_EFF_M1_O, keff())
    `CHK("link_rst", LINK_RST_O, m_en == 0)
    `CHK("serdes_pd", SERDES_PD_O, m_en == 0)
    `CHK("clk_gate", CLK_GATE_EN_O, m_en == 1)
    `CHK("ts_recv", TS_RECV_EN_O, m_ts[0])
    `CHK("cal_en", CAL_EN_O, m_cal[0])
    if (m_en == 0) `CHK("adc_ready", ADC_READY_O, 1'b0)
  endtask
  task automatic rd_chk(input logic [9:0] a);
    logic [31:0] st;
    dcmd(1'b0, a, 8'h00, st);
    `CHK("readback", st[15:8], rd_exp(a))
    m_refl = 0;
  endtask
  task automatic op(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] st;
    logic        r;
    r = refuse(a, d);
    dcmd(1'b1, a, d, st);
    `CHK("refused", st[1], r)
    if (!r) begin
      case (a)
        10'h160: m_ts = d & 8'h01;
        10'h200: m_en = d & 8'h01;
        10'h201: m_mode = d & 8'h3F;
        10'h202: m_km1 = d;
        default: ;
      endcase
    end
    if (m_en == 0) mf = 0;
    rd_chk(a);
    out_chk();
  endtask
  task automatic cal(input int b);
    logic r;
    r = (b == 0 && m_en == 1);
    apb(1'b1, 8'h08, 32'(b), q);
    if (r) m_refl = 1;
    else m_cal = b;
    apb(1'b0, 8'h04, 32'h0000_0000, q);
    `CHK("cal_refused", q[1], m_refl[0])
    out_chk();
  endtask
  ////////////////////////////////////////
  // Far side of the link: random stalls, in-order compare, multiframe count
  always @(posedge CLK_SYS_I) begin
    if (LINK_VALID_O === 1'b1 && LINK_READY_I === 1'b1) begin
      sink_w = exp_q.pop_front();
      `CHK("link_data", LINK_DATA_O, sink_w)
      `CHK("mf_count", MF_COUNT_O, mf[7:0])
      mf = (mf >= keff()) ? 0 : mf + 1;
    end
    LINK_READY_I <= sink_on && ($urandom % 3 != 0);
  end
  task automatic send(input int n);
    int i;
    int g;
    i = 0;
    g = 0;
    smp = 12'($urandom);
    ts = 1'($urandom);
    ADC_SAMPLE_I <= smp;
    ADC_TIMESTAMP_I <= ts;
    ADC_VALID_I <= 1'b1;
    while (i < n && g < 500) begin
      @(posedge CLK_SYS_I);
      g++;
      if (ADC_READY_O === 1'b1) begin
        exp_q.push_back({smp, 3'h0, ts & m_ts[0]});
        i++;
        smp = 12'($urandom);
        ts = 1'($urandom);
        ADC_SAMPLE_I <= smp;
        ADC_TIMESTAMP_I <= ts;
      end
    end
    ADC_VALID_I <= 1'b0;
    if (i < n) tmo();
  endtask
  task automatic stream(input int mode, input int km1, input int tse);
    int g;
    op(10'h200, 8'h00);
    cal(0);
    op(10'h201, 8'(mode));
    op(10'h202, 8'(km1));
    op(10'h160, 8'(tse));
    cal(1);
    op(10'h200, 8'h01);
    send(serial_link_tx_pkg::FIFO_DEPTH + 1);
    repeat (4) @(posedge CLK_SYS_I);
    `CHK("fifo_full", ADC_READY_O, 1'b0)
    sink_on = 1'b1;
    send(40);
    g = 0;
    while (exp_q.size() != 0 && g < 400) begin
      @(posedge CLK_SYS_I);
      g++;
    end
    if (exp_q.size() != 0) tmo();
    sink_on = 1'b0;
    repeat (2) @(posedge CLK_SYS_I);
    $display("test stream mode %0h done", mode);
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(41));
    m_ts = 0;
    m_en = 1;
    m_mode = 0;
    m_km1 = 8'h1F;
    m_cal = 0;
    m_refl = 0;
    mf = 0;
    repeat (2) @(posedge CLK_SYS_I);
    SRST_I <= 1'b0;
    foreach (addrs[k]) rd_chk(addrs[k]);
    out_chk();
    apb(1'b0, 8'h0C, 32'h0000_0000, q);
    `CHK("unmapped", q, 32'h0000_0000)
    `CHK("pslverr", PSLVERR_O, 1'b0)
    $display("test reset_values done");
    op(10'h201, 8'h05);
    cal(0);
    cal(1);
    cal(0);
    for (int i = 0; i < 60; i++) begin
      if ($urandom % 5 == 0) cal(int'($urandom % 2));
      else op(addrs[$urandom % 5], 8'($urandom));
    end
    $display("test interlocks done");
    stream(6'h05, 8'h03, 0);
    stream(6'h23, 8'h10, 1);
    send(3);
    op(10'h200, 8'h00);
    `CHK("flushed", LINK_VALID_O, 1'b0)
    `CHK("mf_rst", MF_COUNT_O, 8'h00)
    exp_q.delete();
    SYSREF_I <= 1'b1;
    repeat (4) @(posedge CLK_SYS_I);
    SYSREF_I <= 1'b0;
    repeat (4) @(posedge CLK_SYS_I);
    `CHK("mf_held", MF_COUNT_O, 8'h00)
    $display("test disable done");
    SRST_I <= 1'b1;
    repeat (2) @(posedge CLK_SYS_I);
    SRST_I <= 1'b0;
    m_ts = 0;
    m_en = 1;
    m_mode = 0;
    m_km1 = 8'h1F;
    m_cal = 0;
    foreach (addrs[k]) rd_chk(addrs[k]);
    out_chk();
    $display("test second_reset done");
    print_verdict();
  end
endmodule
